// [sccc_pin_model.sv]
// Outside world of the channel pins: one external source per pin.
// Assumes the bench sets ext_level; a driving channel wins its pin.
`timescale 1ns/1ps
module sccc_pin_model
(
  input  wire logic [15:0] ext_level,     // Outside level
  input  wire logic [15:0] chan_pin_out,  // Unit level
  input  wire logic [15:0] chan_pin_oe_n, // Low drives
  output logic      [15:0] chan_pin_in    // Pin level
);
  assign chan_pin_in = (chan_pin_oe_n & ext_level) | (~chan_pin_oe_n & chan_pin_out);
endmodule // sccc_pin_model

// [sccc_pkg.sv]
// Package for the sixteen channel capture/compare unit: widths, reset values, mode codes.
// Assumes a single 20 MHz system clock and a synchronous active-high reset.
package sccc_pkg;

  localparam int unsigned SCCC_CHANNELS    = 16;
  localparam int unsigned SCCC_TIMERS      = 2;
  localparam int unsigned SCCC_WIDTH       = 16;
  localparam int unsigned SCCC_PAIRS       = 8;

  // Clock rate and the staggered-mode slot length
  localparam int unsigned SCCC_CLOCK_HZ    = 20_000_000;
  localparam int unsigned SCCC_STAGGER_CYC = 8;
  localparam int unsigned SCCC_STAGGER_W   = 3;

  // Prescaler: divide by 2**sel, sel in 0..7
  localparam int unsigned SCCC_PRESC_SEL_W = 3;
  localparam int unsigned SCCC_PRESC_W     = 7;

  // Reset values
  localparam logic [15:0] SCCC_CNT_RST     = 16'h0000;
  localparam logic [15:0] SCCC_RLD_RST     = 16'h0000;
  localparam logic [15:0] SCCC_CHAN_RST    = 16'h0000;
  localparam logic [15:0] SCCC_CNT_MAX     = 16'hffff;
  localparam logic [2:0]  SCCC_PHASE_RST   = 3'h0;
  localparam logic [6:0]  SCCC_PRESC_RST   = 7'h00;

  // Timer clock sources
  typedef enum logic [1:0] {
    SCCC_SRC_PRESC = 2'b00,
    SCCC_SRC_AUX   = 2'b01,
    SCCC_SRC_EXT   = 2'b10,
    SCCC_SRC_STOP  = 2'b11
  } sccc_src_t;

  // Channel modes: bit 2 marks a compare mode
  typedef enum logic [2:0] {
    SCCC_OFF  = 3'b000,
    SCCC_CAP  = 3'b001,
    SCCC_RSV2 = 3'b010,
    SCCC_RSV3 = 3'b011,
    SCCC_CMP0 = 3'b100,
    SCCC_CMP1 = 3'b101,
    SCCC_CMP2 = 3'b110,
    SCCC_CMP3 = 3'b111
  } sccc_mode_t;

  // Capture edge selection
  localparam logic [1:0] SCCC_EDGE_RISE = 2'b01;
  localparam logic [1:0] SCCC_EDGE_FALL = 2'b10;
  localparam logic [1:0] SCCC_EDGE_BOTH = 2'b11;

  // Mask whose low sel bits are set; a prescaler tick when counter matches it
  function automatic logic [6:0] sccc_presc_mask(input logic [2:0] sel);
    sccc_presc_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  // Edge detection for a selected transition
  function automatic logic sccc_edge_hit(input logic [1:0] sel, input logic prev,
                                         input logic now);
    sccc_edge_hit = (sel[0] && !prev && now) || (sel[1] && prev && !now);
  endfunction

  function automatic logic sccc_is_cmp(input sccc_mode_t mode);
    sccc_is_cmp = mode[2];
  endfunction

endpackage

// [sccc_timer.sv]
// One 16-bit reloadable time base of the capture/compare unit.
// Assumes ce, the aux overflow pulse and the external count input are synchronous.
`timescale 1ns/1ps
module sccc_timer
  import sccc_pkg::*;
(
  input  wire logic        clock,     // System clock
  input  wire logic        sys_rst,   // Synchronous reset, active high
  input  wire logic        ce,        // Clock enable, freezes state when low
  input  wire logic        slot_ok,   // Stagger slot: count only when high
  input  wire logic [1:0]  src,       // Clock source select
  input  wire logic [2:0]  presc,     // Prescaler select, divide by 2**presc
  input  wire logic        aux_ovf,   // Auxiliary timer overflow pulse
  input  wire logic        ext_cnt,   // External count input, rising edges count
  input  wire logic        wr_cnt,    // Write count value
  input  wire logic        wr_rld,    // Write reload value
  input  wire logic [15:0] wr_data,   // Write data
  output logic      [15:0] count,     // Present count
  output logic             upd,       // Count ticked in the previous edge
  output logic             ovf        // Overflow happened in the previous edge
);

  logic [15:0] reload;
  logic [6:0]  presc_cnt;
  logic        ext_prev;
  logic        ext_primed;
  logic        tick;

  always_comb
  begin
    case (sccc_src_t'(src))
      SCCC_SRC_PRESC: tick = (presc_cnt & sccc_presc_mask(presc)) == sccc_presc_mask(presc);
      SCCC_SRC_AUX:   tick = aux_ovf;
      // A high input at reset release is not taken as a count edge
      SCCC_SRC_EXT:   tick = ext_cnt && !ext_prev && ext_primed;
      default:        tick = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      presc_cnt  <= SCCC_PRESC_RST;
      ext_prev   <= 1'b0;
      ext_primed <= 1'b0;
    end
    else if (ce)
    begin
      presc_cnt  <= presc_cnt + 7'h01;
      ext_prev   <= ext_cnt;
      ext_primed <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      reload <= SCCC_RLD_RST;
    else if (ce && wr_rld)
      reload <= wr_data;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      count <= SCCC_CNT_RST;
      upd   <= 1'b0;
      ovf   <= 1'b0;
    end
    else if (ce)
    begin
      upd <= 1'b0;
      ovf <= 1'b0;
      if (wr_cnt)
        count <= wr_data;
      // ticks from prescaler or aux overflow; external counts
      else if (tick && slot_ok)
      begin
        upd <= 1'b1;
        // overflow reloads and counting continues from there
        if (count == SCCC_CNT_MAX)
        begin
          count <= reload;
          ovf   <= 1'b1;
        end
        else
          count <= count + 16'h0001;
      end
    end
  end

endmodule // sccc_timer

// [sccc_top.sv]
// Sixteen channel capture/compare unit: two time bases and sixteen channel registers.
// Assumes all inputs synchronous to clock; configuration is held on plain ports.
`timescale 1ns/1ps
module sccc_top
  import sccc_pkg::*;
(
  input  wire logic              clock,                    // System clock, 20 MHz
  input  wire logic              sys_rst,                  // Synchronous reset
  input  wire logic              ce,                       // Clock enable for all state
  input  wire logic              stagger_en,               // Staggered operation
  input  wire logic [1:0][1:0]   tmr_src,                  // Per timer clock source
  input  wire logic [1:0][2:0]   tmr_presc,                // Per timer prescaler select
  input  wire logic              auxiliary_clock_timer_ovf, // Aux timer overflow pulse
  input  wire logic [1:0]        ext_count,                // External count inputs
  input  wire logic [1:0]        tmr_wr,                   // Write timer count
  input  wire logic [1:0]        rld_wr,                   // Write timer reload
  input  wire logic [15:0]       wr_data,                  // Shared write data
  input  wire logic [15:0]       chan_wr,                  // Write channel register, rearms
  input  wire logic [15:0][2:0]  chan_mode,                // Channel mode code
  input  wire logic [15:0]       chan_tsel,                // Timer select, 1 = timer 1
  input  wire logic [15:0][1:0]  chan_edge,                // Capture edge select
  input  wire logic [15:0]       chan_single,              // Single event option
  input  wire logic [7:0]        dbl_en,                   // Pair n with n+8 on pin n
  input  wire logic [15:0]       chan_pin_in,              // Channel pin levels
  output logic      [15:0][15:0] chan_value,               // Channel registers
  output logic      [15:0]       chan_pin_out,             // Channel pin drive level
  output logic      [15:0]       chan_pin_oe_n,            // Pin enable, low drives
  output logic      [15:0]       chan_irq,                 // Channel interrupt pulses
  output logic      [15:0]       chan_armed,               // Compare armed state
  output logic      [1:0][15:0]  tmr_count,                // Timer counts
  output logic      [1:0]        tmr_ovf                   // Timer overflow pulses
);

  logic [2:0]       phase;
  logic             slot_ok;
  logic [1:0][15:0] cnt;
  logic [1:0]       upd;
  logic [1:0]       ovf;
  logic [15:0]      cmp_hit;
  logic [15:0]      cap_hit;
  logic [15:0]      pin_prev;
  logic [15:0]      period_done;
  logic             pin_primed;
  logic [7:0]       pair_on;
  logic [7:0]       pair_tog;

  // Modes 2 and 3 let only one event through per timer period
  function automatic logic sccc_once(input sccc_mode_t mode);
    sccc_once = (mode == SCCC_CMP2) || (mode == SCCC_CMP3);
  endfunction

  // Picks the allocated timer's one-bit status
  function automatic logic sccc_pick(input logic tsel, input logic [1:0] bits);
    sccc_pick = tsel ? bits[1] : bits[0];
  endfunction

  // First sample after reset only loads the pin history, so a pin that
  // idles high cannot fake a rising edge right after reset
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      pin_primed <= 1'b0;
    else if (ce)
      pin_primed <= 1'b1;
  end

  // staggered mode lets the timers step once per eight-cycle slot
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      phase <= SCCC_PHASE_RST;
    else if (ce)
      phase <= phase + 3'h1;
  end

  assign slot_ok = !stagger_en || (phase == SCCC_PHASE_RST);

  generate
    for (genvar t = 0; t < SCCC_TIMERS; t++)
    begin : g_tmr
      sccc_timer u_timer (
        .clock   (clock),
        .sys_rst (sys_rst),
        .ce      (ce),
        .slot_ok (slot_ok),
        .src     (tmr_src[t]),
        .presc   (tmr_presc[t]),
        .aux_ovf (auxiliary_clock_timer_ovf),
        .ext_cnt (ext_count[t]),
        .wr_cnt  (tmr_wr[t]),
        .wr_rld  (rld_wr[t]),
        .wr_data (wr_data),
        .count   (cnt[t]),
        .upd     (upd[t]),
        .ovf     (ovf[t])
      );
    end
  endgenerate

  assign tmr_count = cnt;
  assign tmr_ovf   = ovf;

  // a pair is live only while both halves compare
  generate
    for (genvar n = 0; n < SCCC_PAIRS; n++)
    begin : g_pair
      assign pair_on[n]  = dbl_en[n] && sccc_is_cmp(sccc_mode_t'(chan_mode[n]))
                           && sccc_is_cmp(sccc_mode_t'(chan_mode[n + SCCC_PAIRS]));
      // Simultaneous matches of both halves give a single toggle
      assign pair_tog[n] = cmp_hit[n] || cmp_hit[n + SCCC_PAIRS];
    end
  endgenerate

  // Per-channel logic
  generate
    for (genvar i = 0; i < SCCC_CHANNELS; i++)
    begin : g_chan
      localparam bit  LOW  = (i < SCCC_PAIRS);
      sccc_mode_t     mode;
      logic [15:0]    tcnt;
      logic           tupd;
      logic           tovf;
      logic           dbl;
      logic           once_mode;
      logic           drives;
      logic           tog;
      logic           set_hi;
      logic           clr_lo;

      assign mode = sccc_mode_t'(chan_mode[i]);
      assign tcnt = chan_tsel[i] ? cnt[1] : cnt[0];
      assign tupd = sccc_pick(chan_tsel[i], upd);
      assign tovf = sccc_pick(chan_tsel[i], ovf);
      assign dbl  = pair_on[i % SCCC_PAIRS];
      assign once_mode = sccc_once(mode);

      // compare on each new timer value
      assign cmp_hit[i] = sccc_is_cmp(mode) && chan_armed[i] && tupd
                          && (tcnt == chan_value[i])
                          // one match per period in modes 2 and 3
                          && !(once_mode && period_done[i]);

      // selectable capture edge on the channel pin
      assign cap_hit[i] = (mode == SCCC_CAP) && pin_primed
                          && sccc_edge_hit(chan_edge[i], pin_prev[i], chan_pin_in[i]);

      always_ff @(posedge clock)
      begin
        if (sys_rst)
          pin_prev[i] <= 1'b0;
        else if (ce)
          pin_prev[i] <= chan_pin_in[i];
      end

      // capture latches the allocated timer; a write takes precedence
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          chan_value[i] <= SCCC_CHAN_RST;
        else if (ce)
        begin
          if (chan_wr[i])
            chan_value[i] <= wr_data;
          else if (cap_hit[i])
            chan_value[i] <= tcnt;
        end
      end

      // capture and compare events pulse the channel's own request
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          chan_irq[i] <= 1'b0;
        else if (ce)
          chan_irq[i] <= cap_hit[i] || cmp_hit[i];
      end

      // single-event channels disarm on their match; a write rearms
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          chan_armed[i] <= 1'b1;
        else if (ce)
        begin
          if (chan_wr[i])
            chan_armed[i] <= 1'b1;
          // single event works with every compare mode
          else if (cmp_hit[i] && chan_single[i])
            chan_armed[i] <= 1'b0;
        end
      end

      // period flag cleared by overflow; a match in the same cycle wins
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          period_done[i] <= 1'b0;
        else if (ce)
        begin
          if (chan_wr[i])
            period_done[i] <= 1'b0;
          else if (cmp_hit[i])
            period_done[i] <= 1'b1;
          else if (tovf)
            period_done[i] <= 1'b0;
        end
      end

      // Pin actions; the upper channel of an active pair gives up its own pin
      always_comb
      begin
        tog    = 1'b0;
        set_hi = 1'b0;
        clr_lo = 1'b0;
        drives = 1'b0;
        if (dbl && LOW)
        begin
          // both matches of the pair toggle the lower channel's pin
          tog    = pair_tog[i % SCCC_PAIRS];
          drives = 1'b1;
        end
        else if (!dbl)
        begin
          case (mode)
            SCCC_CMP1:
            begin
              tog    = cmp_hit[i];
              drives = 1'b1;
            end
            // set on match, cleared by overflow of the allocated timer
            SCCC_CMP3:
            begin
              set_hi = cmp_hit[i];
              clr_lo = tovf;
              drives = 1'b1;
            end
            // modes 0 and 2 leave the pin alone
            default:
            begin
              tog    = 1'b0;
              drives = 1'b0;
            end
          endcase
        end
      end

      // one pin per channel, output in compare modes 1 and 3 outside a live pair and for the lower half of a live pair, input otherwise
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          chan_pin_oe_n[i] <= 1'b1;
        else if (ce)
          chan_pin_oe_n[i] <= !drives;
      end

      // A match at overflow in mode 3 leaves the pin high: set beats clear
      always_ff @(posedge clock)
      begin
        if (sys_rst)
          chan_pin_out[i] <= 1'b0;
        else if (ce)
        begin
          if (tog)
            chan_pin_out[i] <= !chan_pin_out[i];
          else if (set_hi)
            chan_pin_out[i] <= 1'b1;
          else if (clr_lo)
            chan_pin_out[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule // sccc_top

// [sccc_top_sva.sv]
// Checker bound to the capture/compare top module.
// Assumes channel 1 and pair 0/8 carry the compare cases; ce gates the timer step check.
`timescale 1ns/1ps
module sccc_top_sva
  import sccc_pkg::*;
(
  input wire logic              clock,         // Clock
  input wire logic              sys_rst,       // Reset
  input wire logic              ce,            // Clock enable
  input wire logic              stagger_en,    // Stagger
  input wire logic [1:0][1:0]   tmr_src,       // Sources
  input wire logic [1:0][2:0]   tmr_presc,     // Prescalers
  input wire logic [1:0]        tmr_wr,        // Count writes
  input wire logic [15:0]       chan_wr,       // Channel writes
  input wire logic [15:0][2:0]  chan_mode,     // Modes
  input wire logic [15:0]       chan_tsel,     // Timer selects
  input wire logic [15:0][1:0]  chan_edge,     // Edges
  input wire logic [15:0]       chan_single,   // Single event
  input wire logic [7:0]        dbl_en,        // Pairing
  input wire logic [15:0]       chan_pin_in,   // Pin levels
  input wire logic [15:0][15:0] chan_value,    // Channel registers
  input wire logic [15:0]       chan_pin_out,  // Pin drive
  input wire logic [15:0]       chan_pin_oe_n, // Pin enables
  input wire logic [15:0]       chan_irq,      // Requests
  input wire logic [15:0]       chan_armed,    // Armed
  input wire logic [1:0][15:0]  tmr_count,     // Counts
  input wire logic [1:0]        tmr_ovf        // Overflows
);
  logic seen2;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Lenient: a request coinciding with overflow counts for the old period
  always_ff @(posedge clock)
  begin
    if (sys_rst || tmr_ovf[0] || chan_wr[1])
      seen2 <= 1'b0;
    else if (chan_irq[1])
      seen2 <= 1'b1;
  end
  sequence s_rise0;
    $rose(chan_pin_in[0]) && chan_mode[0] == SCCC_CAP && !chan_tsel[0] && !chan_wr[0];
  endsequence
  property p_cap;
    s_rise0 ##0 chan_edge[0][0] |=> chan_irq[0] && chan_value[0] == $past(tmr_count[0]);
  endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");
  property p_presc;
    ce && tmr_src[0] == SCCC_SRC_PRESC && tmr_presc[0] == 3'h0 && !stagger_en && !tmr_wr[0]
      |=> tmr_ovf[0] || tmr_count[0] == $past(tmr_count[0]) + 16'h1;
  endproperty
  a_presc: assert property (p_presc) else $error("timer step wrong");
  property p_ovf;
    tmr_ovf[0] |-> $past(tmr_count[0]) == SCCC_CNT_MAX;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow early");
  property p_cmp1;
    chan_mode[1] == SCCC_CMP1 && !dbl_en[1] && $stable(chan_mode[1]) && !$past(sys_rst)
      |-> chan_irq[1] == $changed(chan_pin_out[1]);
  endproperty
  a_cmp1: assert property (p_cmp1) else $error("toggle wrong");
  property p_cmp2;
    chan_irq[1] && chan_mode[1] == SCCC_CMP2 |-> !seen2;
  endproperty
  a_cmp2: assert property (p_cmp2) else $error("second request");
  property p_cmp3;
    tmr_ovf[0] && chan_mode[1] == SCCC_CMP3 && !chan_tsel[1] && chan_value[1] != tmr_count[0]
      |=> !chan_pin_out[1];
  endproperty
  a_cmp3: assert property (p_cmp3) else $error("pin not cleared");
  property p_dbl;
    dbl_en[0] && chan_mode[0] == SCCC_CMP1 && chan_mode[8] == SCCC_CMP1 && !$past(sys_rst)
      && (chan_irq[0] || chan_irq[8]) |-> $changed(chan_pin_out[0]) && chan_pin_oe_n[8];
  endproperty
  a_dbl: assert property (p_dbl) else $error("shared pin wrong");
  property p_single;
    chan_irq[1] && chan_single[1] && chan_mode[1][2] |-> ##[0:1] !chan_armed[1];
  endproperty
  a_single: assert property (p_single) else $error("still armed");
  property p_disarm;
    !chan_armed[1] && $past(chan_armed[1]) == 1'b0 |-> !chan_irq[1];
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarmed match");
endmodule // sccc_top_sva

bind sccc_top sccc_top_sva u_sva (.*);

// [tb_sccc_top.sv]
// Bench for the capture/compare unit with its pin model.
// Assumes ce stays high except for the final freeze check; timer 0 runs from the undivided clock.
`timescale 1ns/1ps
module tb_sccc_top
  import sccc_pkg::*;
();
  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic              ce = 1'b1;
  logic              stagger_en = 1'b0;
  logic [1:0][1:0]   tmr_src = 4'hc;
  logic [1:0][2:0]   tmr_presc = 6'h0;
  logic              auxiliary_clock_timer_ovf = 1'b0;
  logic [1:0]        ext_count = 2'h0;
  logic [1:0]        tmr_wr = 2'h0;
  logic [1:0]        rld_wr = 2'h0;
  logic [15:0]       wr_data = 16'h0;
  logic [15:0]       chan_wr = 16'h0;
  logic [15:0][2:0]  chan_mode = 48'h0;
  logic [15:0]       chan_tsel = 16'h0;
  logic [15:0][1:0]  chan_edge = 32'h0;
  logic [15:0]       chan_single = 16'h0;
  logic [7:0]        dbl_en = 8'h0;
  logic [15:0]       ext_level = 16'h0;
  logic [15:0]       chan_pin_in;
  logic [15:0][15:0] chan_value;
  logic [15:0]       chan_pin_out;
  logic [15:0]       chan_pin_oe_n;
  logic [15:0]       chan_irq;
  logic [15:0]       chan_armed;
  logic [1:0][15:0]  tmr_count;
  logic [1:0]        tmr_ovf;
  int                fails = 0;
  int                compares = 0;
  int                irq_n = 0;

  sccc_top dut (.*);
  sccc_pin_model pins (.*);

  always #25 clock = ~clock;
  always @(posedge clock)
    if (chan_irq[1] === 1'b1)
      irq_n++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Strobes last one cycle, data held with them
  task automatic wr_tmr(input int t, input logic [15:0] d, input logic rl);
    wr_data = d;
    rld_wr[t] = rl;
    tmr_wr[t] = !rl;
    step(1);
    rld_wr = 2'h0;
    tmr_wr = 2'h0;
  endtask
  task automatic wr_chan(input int i, input logic [15:0] d);
    wr_data = d;
    chan_wr[i] = 1'b1;
    step(1);
    chan_wr = 16'h0;
  endtask
  task automatic print_verdict();
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #1000000;
    fails++;
    print_verdict();
  end

  initial
  begin
    logic [15:0] c;
    logic        p;
    int          n0;
    step(12);
    sys_rst = 1'b0;
    check(tmr_count[1], 16'h0);
    check(chan_pin_oe_n, 16'hffff);
    check(chan_armed, 16'hffff);
    wr_tmr(0, 16'hfff0, 1'b1);
    wr_tmr(0, 16'hfffd, 1'b0);
    step(3);
    check(tmr_count[0], 16'hfff0);
    check(tmr_ovf[0], 1'b1);
    check(tmr_count[1], 16'h0);
    tmr_presc[1] = 3'h2;
    tmr_src[1] = SCCC_SRC_PRESC;
    c = tmr_count[1];
    step(16);
    tmr_src[1] = SCCC_SRC_AUX;
    check(tmr_count[1], c + 16'h4);
    repeat (3)
    begin
      auxiliary_clock_timer_ovf = 1'b1;
      step(1);
      auxiliary_clock_timer_ovf = 1'b0;
      step(1);
    end
    check(tmr_count[1], c + 16'h7);
    tmr_src[1] = SCCC_SRC_EXT;
    repeat (2)
    begin
      ext_count[1] = 1'b1;
      step(2);
      ext_count[1] = 1'b0;
      step(2);
    end
    check(tmr_count[1], c + 16'h9);
    tmr_src[1] = SCCC_SRC_STOP;
    chan_mode[0] = SCCC_CAP;
    for (int e = 1; e < 4; e++)
      for (int v = 1; v >= 0; v--)
      begin
        chan_edge[0] = 2'(e);
        c = tmr_count[0];
        ext_level[0] = v[0];
        step(1);
        check(chan_irq[0], 16'(v ? e % 2 : e / 2));
        if (chan_irq[0] === 1'b1)
          check(chan_value[0], c);
      end
    wr_tmr(1, 16'h0abc, 1'b0);
    chan_tsel[0] = 1'b1;
    ext_level[0] = 1'b1;
    step(1);
    check(chan_value[0], 16'h0abc);
    chan_mode[0] = SCCC_OFF;
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 4; k++)
      begin
        chan_mode[1] = 3'(4 + k);
        chan_single[1] = s[0];
        wr_tmr(0, 16'hfff0, 1'b0);
        wr_chan(1, 16'hfff8);
        p = chan_pin_out[1];
        n0 = irq_n;
        step(10);
        check(16'(irq_n - n0), 16'h1);
        check(chan_pin_out[1], k == 1 ? !p : k == 3 ? 1'b1 : p);
        check(chan_armed[1], !s[0]);
        wr_tmr(0, 16'hfff0, 1'b0);
        step(10);
        check(16'(irq_n - n0), (s == 0 && k < 2) ? 16'h2 : 16'h1);
        step(10);
        check(chan_pin_out[1], k == 3 ? 1'b0 : (k == 1 && s == 1) ? !p : p);
      end
    chan_mode[1] = SCCC_OFF;
    dbl_en[0] = 1'b1;
    chan_tsel[0] = 1'b0;
    chan_mode[0] = SCCC_CMP1;
    chan_mode[8] = SCCC_CMP1;
    wr_chan(0, 16'hfff4);
    wr_chan(8, 16'hfff8);
    p = chan_pin_out[0];
    wr_tmr(0, 16'hfff0, 1'b0);
    step(6);
    check(chan_pin_out[0], !p);
    step(5);
    check(chan_pin_out[0], p);
    check({chan_pin_oe_n[8], chan_pin_oe_n[0]}, 16'h2);
    stagger_en = 1'b1;
    wr_tmr(0, 16'h0100, 1'b0);
    step(32);
    check(tmr_count[0], 16'h0104);
    stagger_en = 1'b0;
    ce = 1'b0;
    c = tmr_count[0];
    step(5);
    check(tmr_count[0], c);
    ce = 1'b1;
    step(1);
    check(tmr_count[0], c + 16'h1);
    print_verdict();
  end
endmodule // tb_sccc_top
